// ### common/psiu_map.svh
// register map, field positions, reset values and bus constants of the pll status interrupt unit
`ifndef PSIU_MAP_SVH
`define PSIU_MAP_SVH

`define PSIU_OFS_LIVE 8'h0D
`define PSIU_OFS_MASK 8'h0E
`define PSIU_OFS_POL 8'h0F
`define PSIU_OFS_FLAG 8'h10
`define PSIU_OFS_CTL 8'h11

`define PSIU_RST_MASK 8'h00
`define PSIU_RST_POL 8'h00
`define PSIU_RST_FLAG 4'h0
`define PSIU_RST_CTL 8'h00

// source bit positions inside the live, mask, polarity and flag registers
`define PSIU_BIT_LOCK 7
`define PSIU_BIT_SIGNAL 6
`define PSIU_BIT_TUNING 5
`define PSIU_BIT_REVERT 1

// control register fields
`define PSIU_CTL_AND 1
`define PSIU_CTL_EN 0

// serial bus: last bit index of a byte, read/write bit value for read
`define PSIU_BIT_LAST 3'h7
`define PSIU_RW_READ 1'b1

`endif

// ### common/psiu_pkg.sv
// types of the pll status interrupt unit
package psiu_pkg;

   // serial register port states, gray coded along the usual path
   typedef enum logic [3:0] {
      PSIU_IDLE = 4'h0,
      PSIU_DEV = 4'h1,
      PSIU_DEV_ACK = 4'h3,
      PSIU_PTR = 4'h2,
      PSIU_PTR_ACK = 4'h6,
      PSIU_WDATA = 4'h7,
      PSIU_WDATA_ACK = 4'h5,
      PSIU_RDATA = 4'h4,
      PSIU_RDATA_ACK = 4'hC
   } psiu_bus_state_t;

   // sources in compact order: [3] lock loss, [2] signal loss, [1] tuning, [0] revert
   typedef logic [3:0] psiu_src_t;

   typedef struct packed {
      psiu_src_t prev;
      psiu_src_t flags;
   } psiu_edge_state_t;

   typedef struct packed {
      psiu_bus_state_t st;
      logic scl_q;
      logic sda_q;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic ack_on;
      logic sda_oe;
      logic [7:0] mask;
      logic [7:0] pol;
      logic and_mode;
      logic int_en;
      logic irq;
   } psiu_top_state_t;

endpackage

// ### core/psiu_edge_flags.sv
// edge detection and sticky flags for the four interrupt sources
`timescale 1ns/1ps
`include "psiu_map.svh"
module psiu_edge_flags (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire psiu_pkg::psiu_src_t src_i,
   input wire psiu_pkg::psiu_src_t pol_i,
   input wire logic enable_i,
   input wire psiu_pkg::psiu_src_t clear_i,
   output psiu_pkg::psiu_src_t flags_o
);
   import psiu_pkg::*;

   psiu_edge_state_t r_reg;
   psiu_edge_state_t r_next;
   psiu_src_t rise;
   psiu_src_t fall;
   psiu_src_t set;

   always_comb begin
      r_next = r_reg;
      rise = src_i & ~r_reg.prev;
      fall = ~src_i & r_reg.prev;
      set = (pol_i & rise) | (~pol_i & fall);
      if (!enable_i) begin
         set = 4'h0;
      end
      r_next.prev = src_i;
      // a matching edge in the cycle of a clearing write wins
      r_next.flags = (r_reg.flags & ~clear_i) | set;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         r_reg <= '{prev: 4'h0, flags: `PSIU_RST_FLAG};
      end else begin
         r_reg <= r_next;
      end
   end

   assign flags_o = r_reg.flags;

endmodule

// ### core/psiu_top.sv
// serial register port, register file and interrupt combiner of the pll status interrupt unit
`timescale 1ns/1ps
`include "psiu_map.svh"
module psiu_top #(
   // 7-bit serial bus device address, value arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic lock_loss_source_i,
   input wire logic input_signal_loss_source_i,
   input wire logic tuning_source_i,
   input wire logic reference_revert_source_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic irq_o
);
   import psiu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // compact source vector to register layout
   function automatic logic [7:0] to_reg(input psiu_src_t v);
      logic [7:0] b;
      b = 8'h00;
      b[`PSIU_BIT_LOCK] = v[3];
      b[`PSIU_BIT_SIGNAL] = v[2];
      b[`PSIU_BIT_TUNING] = v[1];
      b[`PSIU_BIT_REVERT] = v[0];
      return b;
   endfunction

   // register layout to compact source vector
   function automatic psiu_src_t from_reg(input logic [7:0] b);
      return {b[`PSIU_BIT_LOCK], b[`PSIU_BIT_SIGNAL], b[`PSIU_BIT_TUNING], b[`PSIU_BIT_REVERT]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state and sources

   psiu_top_state_t r_reg;
   psiu_top_state_t r_next;
   psiu_src_t live;
   psiu_src_t flags;
   psiu_src_t clear;
   psiu_src_t unmasked;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [7:0] in_byte;
   logic [7:0] rd_byte;
   logic [7:0] ptr_inc;
   logic combined;

   // sources are read straight, the enable plays no part here
   assign live = {lock_loss_source_i, input_signal_loss_source_i, tuning_source_i,
      reference_revert_source_i};

   psiu_edge_flags u_flags (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .src_i(live),
      .pol_i(from_reg(r_reg.pol)),
      .enable_i(r_reg.int_en),
      .clear_i(clear),
      .flags_o(flags)
   );

   assign scl_rise = scl_i & ~r_reg.scl_q;
   assign scl_fall = ~scl_i & r_reg.scl_q;
   assign start_seen = scl_i & r_reg.scl_q & r_reg.sda_q & ~sda_i;
   assign stop_seen = scl_i & r_reg.scl_q & ~r_reg.sda_q & sda_i;
   assign in_byte = {r_reg.sh[6:0], sda_i};
   assign ptr_inc = r_reg.ptr + 8'h01;

   ////////////////////////////////////////////////////////////////////////////////
   // register read

   always_comb begin
      case (r_reg.ptr)
         `PSIU_OFS_LIVE: rd_byte = to_reg(live);
         `PSIU_OFS_MASK: rd_byte = r_reg.mask;
         `PSIU_OFS_POL: rd_byte = r_reg.pol;
         `PSIU_OFS_FLAG: rd_byte = to_reg(flags);
         `PSIU_OFS_CTL: begin
            rd_byte = 8'h00;
            rd_byte[`PSIU_CTL_AND] = r_reg.and_mode;
            rd_byte[`PSIU_CTL_EN] = r_reg.int_en;
         end
         default: rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt combiner

   assign unmasked = flags & ~from_reg(r_reg.mask);

   always_comb begin
      if (r_reg.and_mode) begin
         // every unmasked flag high, and at least one source unmasked
         combined = ((flags | from_reg(r_reg.mask)) == 4'hF) && (from_reg(r_reg.mask) != 4'hF);
      end else begin
         combined = |unmasked;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial register port and register writes

   always_comb begin
      r_next = r_reg;
      clear = 4'h0;
      r_next.scl_q = scl_i;
      r_next.sda_q = sda_i;
      r_next.irq = r_reg.int_en & combined;

      case (r_reg.st)
         PSIU_IDLE: begin
            r_next.sda_oe = 1'b0;
         end
         PSIU_DEV, PSIU_PTR, PSIU_WDATA: begin
            if (scl_rise) begin
               r_next.sh = in_byte;
               r_next.cnt = r_reg.cnt + 3'h1;
               if (r_reg.cnt == `PSIU_BIT_LAST) begin
                  r_next.ack_on = 1'b0;
                  case (r_reg.st)
                     PSIU_DEV: begin
                        r_next.st = (in_byte[7:1] == DEV_ADDR) ? PSIU_DEV_ACK : PSIU_IDLE;
                     end
                     PSIU_PTR: begin
                        r_next.ptr = in_byte;
                        r_next.st = PSIU_PTR_ACK;
                     end
                     default: begin
                        r_next.st = PSIU_WDATA_ACK;
                        r_next.ptr = ptr_inc;
                        case (r_reg.ptr)
                           `PSIU_OFS_MASK: r_next.mask = in_byte;
                           `PSIU_OFS_POL: r_next.pol = in_byte;
                           `PSIU_OFS_FLAG: clear = ~from_reg(in_byte);
                           `PSIU_OFS_CTL: begin
                              r_next.and_mode = in_byte[`PSIU_CTL_AND];
                              r_next.int_en = in_byte[`PSIU_CTL_EN];
                           end
                           default: begin
                           end
                        endcase
                     end
                  endcase
               end
            end
         end
         PSIU_DEV_ACK, PSIU_PTR_ACK, PSIU_WDATA_ACK: begin
            // first falling edge pulls the ack low, the second releases it
            if (scl_fall) begin
               if (!r_reg.ack_on) begin
                  r_next.ack_on = 1'b1;
                  r_next.sda_oe = 1'b1;
               end else begin
                  r_next.ack_on = 1'b0;
                  r_next.sda_oe = 1'b0;
                  r_next.cnt = 3'h0;
                  if (r_reg.st == PSIU_DEV_ACK && r_reg.sh[0] == `PSIU_RW_READ) begin
                     r_next.sh = rd_byte;
                     r_next.sda_oe = ~rd_byte[7];
                     r_next.st = PSIU_RDATA;
                  end else if (r_reg.st == PSIU_DEV_ACK) begin
                     r_next.st = PSIU_PTR;
                  end else begin
                     r_next.st = PSIU_WDATA;
                  end
               end
            end
         end
         PSIU_RDATA: begin
            if (scl_rise) begin
               r_next.cnt = r_reg.cnt + 3'h1;
               if (r_reg.cnt == `PSIU_BIT_LAST) begin
                  r_next.ack_on = 1'b0;
                  r_next.st = PSIU_RDATA_ACK;
               end
            end else if (scl_fall) begin
               r_next.sh = {r_reg.sh[6:0], 1'b0};
               r_next.sda_oe = ~r_reg.sh[6];
            end
         end
         PSIU_RDATA_ACK: begin
            if (scl_fall && !r_reg.ack_on) begin
               r_next.sda_oe = 1'b0;
            end else if (scl_rise) begin
               // master ack is low; a high level ends the read
               r_next.ack_on = 1'b1;
               if (sda_i) begin
                  r_next.st = PSIU_IDLE;
               end else begin
                  r_next.ptr = ptr_inc;
               end
            end else if (scl_fall) begin
               r_next.ack_on = 1'b0;
               r_next.cnt = 3'h0;
               r_next.sh = rd_byte;
               r_next.sda_oe = ~rd_byte[7];
               r_next.st = PSIU_RDATA;
            end
         end
         default: begin
            r_next.st = PSIU_IDLE;
            r_next.sda_oe = 1'b0;
         end
      endcase

      // start and stop override whatever byte is in flight
      if (start_seen) begin
         r_next.st = PSIU_DEV;
         r_next.cnt = 3'h0;
         r_next.sda_oe = 1'b0;
         r_next.ack_on = 1'b0;
      end else if (stop_seen) begin
         r_next.st = PSIU_IDLE;
         r_next.sda_oe = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         r_reg <= '{st: PSIU_IDLE, scl_q: 1'b1, sda_q: 1'b1, cnt: 3'h0, sh: 8'h00, ptr: 8'h00,
            ack_on: 1'b0, sda_oe: 1'b0, mask: `PSIU_RST_MASK, pol: `PSIU_RST_POL,
            and_mode: 1'b0, int_en: 1'b0, irq: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   // open-drain data line only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = r_reg.sda_oe;
   assign irq_o = r_reg.irq;

endmodule

// ### tb/psiu_checker.sv
// port assertions and covers of the pll status interrupt unit
`timescale 1ns/1ps
module psiu_checker (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic lock_loss_source_i,
   input wire logic input_signal_loss_source_i,
   input wire logic tuning_source_i,
   input wire logic reference_revert_source_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic irq_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   wire [3:0] src = {lock_loss_source_i, input_signal_loss_source_i, tuning_source_i, reference_revert_source_i};
   ////////////////////////////////////////////////////////////
   reset_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=> !irq_o && !sda_oe_o)
      else $error("outputs active in reset");
   after_reset_a: assert property ($fell(sys_rst_i) |-> !irq_o ##1 !irq_o)
      else $error("irq right after reset");
   sda_low_a: assert property (!sda_o)
      else $error("data driven high");
   idle_free_a: assert property (scl_i [*8] |-> !sda_oe_o)
      else $error("data held on idle bus");
   oe_rise_a: assert property ($rose(sda_oe_o) |-> !$past(scl_i) && ($past(scl_i, 2) || $past(scl_i, 3)))
      else $error("data pull not after clock fall");
   oe_fall_a: assert property ($fell(sda_oe_o) |-> !$past(scl_i) && ($past(scl_i, 2) || $past(scl_i, 3)))
      else $error("data release not after clock fall");
   oe_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
      else $error("data moved while clock high");
   irq_cause_a: assert property ($changed(irq_o) |-> ($past(src, 4) != src) || $past(scl_i) || $past(scl_i, 2))
      else $error("irq moved with no cause");
   irq_up_c: cover property ($rose(irq_o));
   irq_down_c: cover property ($fell(irq_o));
   ack_c: cover property ($rose(sda_oe_o));
endmodule

// ### tb/psiu_host_model.sv
// serial bus host that services the status registers
`timescale 1ns/1ps
module psiu_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   input wire logic core_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // clock phase length in system clocks, raised for a slow host
   int ph = 4;
   int nacks = 0;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic t(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic bx(input logic b, output logic r);
      sda_o <= b;
      t(ph);
      scl_o <= 1'b1;
      t(ph);
      r = sda_i;
      scl_o <= 1'b0;
      t(2);
   endtask
   task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ar);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bx(d[i], r);
         q[i] = r;
      end
      bx(a, ar);
   endtask
   task automatic go();
      sda_o <= 1'b1;
      t(2);
      scl_o <= 1'b1;
      t(ph);
      sda_o <= 1'b0;
      t(ph);
      scl_o <= 1'b0;
      t(2);
   endtask
   task automatic halt();
      sda_o <= 1'b0;
      t(2);
      scl_o <= 1'b1;
      t(ph);
      sda_o <= 1'b1;
      t(ph);
   endtask
   task automatic snd(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      xb(d, 1'b1, q, a);
      if (a !== 1'b0) begin
         nacks++;
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      go();
      snd({DEV_ADDR, 1'b0});
      snd(p);
      snd(d);
      halt();
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] q);
      logic a;
      go();
      snd({DEV_ADDR, 1'b0});
      snd(p);
      go();
      snd({DEV_ADDR, 1'b1});
      xb(8'hFF, 1'b1, q, a);
      halt();
   endtask
endmodule

// ### tb/tb_psiu_top.sv
// self-checking bench of the pll status interrupt unit
`timescale 1ns/1ps
module tb_psiu_top;
   import psiu_pkg::*;
   typedef struct packed {
      psiu_src_t s0, s1;
      logic [7:0] pol, msk, ctl, flg;
      logic irq;
   } psiu_row_t;
   psiu_row_t rows [11] = '{
      '{4'h0,4'hF,8'hFF,8'h00,8'h01,8'hE2,1'h1}, '{4'hF,4'h0,8'h00,8'h00,8'h01,8'hE2,1'h1},
      '{4'h0,4'hF,8'h00,8'h00,8'h01,8'h00,1'h0}, '{4'hF,4'h0,8'hFF,8'h00,8'h01,8'h00,1'h0},
      '{4'h0,4'h8,8'hFF,8'h80,8'h01,8'h80,1'h0}, '{4'h8,4'h0,8'h00,8'h00,8'h03,8'h80,1'h0},
      '{4'h0,4'h9,8'hFF,8'h60,8'h03,8'h82,1'h1}, '{4'h9,4'h6,8'hA0,8'h00,8'h01,8'h22,1'h1},
      '{4'h6,4'hF,8'hFF,8'hE2,8'h03,8'h82,1'h0}, '{4'hF,4'h0,8'h00,8'h00,8'h00,8'h00,1'h0},
      '{4'h0,4'hF,8'hFF,8'h00,8'h00,8'h00,1'h0}};
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   psiu_src_t src = 4'h0;
   logic scl_i, host_sda, sda_o, sda_oe_o, irq_o;
   // pulled-up data line, low while any party pulls it
   wire sda_i = host_sda & ~(sda_oe_o & ~sda_o);
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   psiu_top psiu_top_inst (.core_clk_i, .sys_rst_i, .lock_loss_source_i(src[3]),
      .input_signal_loss_source_i(src[2]), .tuning_source_i(src[1]), .reference_revert_source_i(src[0]),
      .scl_i, .sda_i, .sda_o, .sda_oe_o, .irq_o);
   psiu_host_model psiu_host_model_inst (.core_clk_i, .sda_i, .scl_o(scl_i), .sda_o(host_sda));
   initial forever #50 core_clk_i = ~core_clk_i;
   task automatic cy(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      psiu_host_model_inst.wr(p, d);
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] q);
      psiu_host_model_inst.rd(p, q);
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 50000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      psiu_row_t r;
      logic [7:0] q;
      cy(16);
      sys_rst_i <= 1'b0;
      cy(1);
      wr(8'h0D, 8'hFF);
      // reset values, then one unmapped place
      for (int p = 8'h0D; p <= 8'h12; p++) begin
         rd(p[7:0], q);
         cmp("reset value", 8'h00, q);
      end
      wr(8'h11, 8'hFF);
      rd(8'h11, q);
      cmp("control", 8'h03, q);
      foreach (rows[i]) begin
         r = rows[i];
         wr(8'h11, 8'h00);
         src <= r.s0;
         wr(8'h0F, r.pol);
         wr(8'h0E, r.msk);
         wr(8'h10, 8'h00);
         wr(8'h11, r.ctl);
         src <= r.s1;
         cy(4);
         cmp("irq", {7'h00, r.irq}, {7'h00, irq_o});
         rd(8'h10, q);
         cmp("flags", r.flg, q);
         rd(8'h0D, q);
         cmp("live", {r.s1[3:1], 3'h0, r.s1[0], 1'h0}, q);
      end
      wr(8'h11, 8'h03);
      src <= 4'h0;
      cy(4);
      src <= 4'hF;
      cy(4);
      cmp("irq all", 8'h01, {7'h00, irq_o});
      wr(8'h10, 8'h7F);
      cy(2);
      cmp("irq part", 8'h00, {7'h00, irq_o});
      psiu_host_model_inst.ph = 6;
      rd(8'h10, q);
      cmp("flags kept", 8'h62, q);
      psiu_host_model_inst.ph = 4;
      wr(8'h11, 8'h01);
      sys_rst_i <= 1'b1;
      cy(16);
      sys_rst_i <= 1'b0;
      cy(2);
      cmp("irq reset", 8'h00, {7'h00, irq_o});
      rd(8'h10, q);
      cmp("flags reset", 8'h00, q);
      cmp("acks", 8'h00, psiu_host_model_inst.nacks[7:0]);
      report_and_stop();
   end
endmodule
bind psiu_top psiu_checker psiu_checker_inst (.core_clk_i, .sys_rst_i, .lock_loss_source_i,
   .input_signal_loss_source_i, .tuning_source_i, .reference_revert_source_i, .scl_i, .sda_i,
   .sda_o, .sda_oe_o, .irq_o);
